/* File: include/mtsrc_pkg.sv */
// Package of constants for the MAC timer sync-reload and configuration block.
// Assumes a 32 MHz system clock and a 24-bit sleep timer supplied from outside.
package mtsrc_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [7:0] CFG_ADDR     = 8'hC3;
    localparam int         CMP_FLAG_BIT = 7;
    localparam int         PER_FLAG_BIT = 6;
    localparam int         OFC_FLAG_BIT = 5;
    localparam int         UNUSED_BIT   = 4;
    localparam int         COMPARE_BYTE_SELECT_BIT    = 3;
    localparam int         RSVD_BIT     = 2;
    localparam int         SYNC_BIT     = 1;
    localparam int         RUN_BIT      = 0;
    localparam logic       SYNC_RESET   = 1'b1;

    // =====================================================================
    // Widths and arithmetic constants
    // =====================================================================
    localparam int SLEEP_W  = 24;
    localparam int TIMER_W  = 16;
    localparam int OVF_W    = 20;
    localparam int FRAC_W   = 4;
    // Clock ratio 976.5625 in fixed point with four fraction bits.
    localparam logic [19:0] CLOCK_RATIO_FX = 20'h03D09;
    localparam logic [15:0] RESTART_OVERHEAD_CYCLES = 16'h004B;
    // Cycles from the sampled sleep edge until the timer runs.
    localparam int          SYNC_START_CYCLES = 75;
    localparam logic [6:0]  SYNC_START_LAST = 7'(SYNC_START_CYCLES - 1);

    typedef enum logic [1:0] {
        MTSRC_IDLE,
        MTSRC_RUN,
        MTSRC_CALC
    } mtsrc_state_t;

endpackage

/* File: design/mtsrc_top.sv */
// Configuration register, run control and synchronous restart reload of the MAC timer.
// Assumes sleep_edge_i is a one-cycle pulse in this clock domain and that the counter
// datapath outside takes the load strobe and the event pulses on this clock.
// How it works
// (RL1) Elapsed ticks wrap by two to the 24.
// (RL2) Count is ticks times ratio plus timer.
// (RL3) Add overhead 75; split into modulo and periods.
// (RL4) Software keeps stop-to-start gap within range.
// (RL5) Compare event sets bit 7 flag.
// (RL6) Period overflow sets bit 6 flag.
// (RL7) Overflow count compare sets bit 5.
// (RL8) Flags clear only on written zero.
// (RL9) Bit 4 always reads zero.
// (RL10) Bit 3 selects compared timer byte.
// (RL11) Software writes zero to reserved bit 2.
// (RL12) Sync bit waits for sleep edge, reloads.
// (RL13) Writing run one starts, zero stops.
// (RL14) Run bit reads actual timer state.
// (RL15) With sync, status changes at takeover only.
// (RL16) Sync stop halts and stores sleep value.
// (RL17) Sync start runs 75 cycles after edge.
// (RL18) Fixed point, round half up, error one.
`timescale 1ns/1ps
`default_nettype none
module mtsrc_top
    import mtsrc_pkg::*;
(
    input  wire logic               core_clk_i,
    input  wire logic               rstn_i,
    input  wire logic               sfr_wr_i,
    input  wire logic [7:0]         sfr_addr_i,
    input  wire logic [7:0]         sfr_wdata_i,
    output logic      [7:0]         cfg_rdata_o,
    input  wire logic               sleep_edge_i,
    input  wire logic [SLEEP_W-1:0] sleep_value_i,
    input  wire logic [TIMER_W-1:0] timer_value_i,
    input  wire logic [TIMER_W-1:0] timer_period_i,
    input  wire logic [OVF_W-1:0]   ovf_count_i,
    input  wire logic               compare_event_i,
    input  wire logic               period_event_i,
    input  wire logic               ovf_compare_event_i,
    output logic                    timer_run_o,
    output logic                    compare_byte_select_o,
    output logic                    reload_o,
    output logic      [TIMER_W-1:0] reload_timer_o,
    output logic      [OVF_W-1:0]   reload_ovf_o
);

    // =====================================================================
    // Configuration register
    // =====================================================================
    logic       cfg_wr;
    logic       cmp_flag_q, cmp_flag_d;
    logic       per_flag_q, per_flag_d;
    logic       ofc_flag_q, ofc_flag_d;
    logic       compare_byte_select_q, compare_byte_select_d;
    logic       rsvd_q, rsvd_d;
    logic       sync_q, sync_d;
    logic       run_req_q, run_req_d;
    logic [7:0] rdata_d;

    assign cfg_wr = sfr_wr_i && (sfr_addr_i == CFG_ADDR);

    always_comb begin
        cmp_flag_d = cmp_flag_q;
        per_flag_d = per_flag_q;
        ofc_flag_d = ofc_flag_q;
        compare_byte_select_d    = compare_byte_select_q;
        rsvd_d     = rsvd_q;
        sync_d     = sync_q;
        run_req_d  = run_req_q;
        if (cfg_wr) begin
            // A written one leaves a flag alone; a written zero clears it.
            cmp_flag_d = cmp_flag_q & sfr_wdata_i[CMP_FLAG_BIT]; // RL8
            per_flag_d = per_flag_q & sfr_wdata_i[PER_FLAG_BIT]; // RL8
            ofc_flag_d = ofc_flag_q & sfr_wdata_i[OFC_FLAG_BIT]; // RL8
            compare_byte_select_d    = sfr_wdata_i[COMPARE_BYTE_SELECT_BIT];
            rsvd_d     = sfr_wdata_i[RSVD_BIT];
            sync_d     = sfr_wdata_i[SYNC_BIT];
            run_req_d  = sfr_wdata_i[RUN_BIT]; // RL13
        end
        // Events set the flags and win over a clear in the same cycle.
        if (compare_event_i) begin
            cmp_flag_d = 1'b1; // RL5
        end
        if (period_event_i) begin
            per_flag_d = 1'b1; // RL6
        end
        if (ovf_compare_event_i) begin
            ofc_flag_d = 1'b1; // RL7
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmp_flag_q <= 1'b0;
            per_flag_q <= 1'b0;
            ofc_flag_q <= 1'b0;
            compare_byte_select_q    <= 1'b0;
            rsvd_q     <= 1'b0;
            sync_q     <= SYNC_RESET;
            run_req_q  <= 1'b0;
        end else begin
            cmp_flag_q <= cmp_flag_d;
            per_flag_q <= per_flag_d;
            ofc_flag_q <= ofc_flag_d;
            compare_byte_select_q    <= compare_byte_select_d;
            rsvd_q     <= rsvd_d;
            sync_q     <= sync_d;
            run_req_q  <= run_req_d;
        end
    end

    // =====================================================================
    // Run state machine and reload arithmetic
    // =====================================================================
    mtsrc_state_t       state_q, state_d;
    logic [6:0]         cnt_q, cnt_d;
    logic [SLEEP_W-1:0] stored_q, stored_d;
    logic [TIMER_W-1:0] ld_timer_q, ld_timer_d;
    logic [OVF_W-1:0]   ld_ovf_q, ld_ovf_d;
    logic               reload_q, reload_d;
    logic [43:0]        calc_q, calc_d;
    logic [SLEEP_W-1:0] ticks_diff;
    logic [SLEEP_W:0]   ticks;
    logic [47:0]        scaled;
    logic [43:0]        whole;
    logic [TIMER_W:0]   rem_q, rem_d;
    logic [OVF_W-1:0]   quo_q, quo_d;
    logic [TIMER_W:0]   rem_shift;

    // Zero or negative difference means the sleep timer wrapped.
    always_comb begin
        ticks_diff = sleep_value_i - stored_q; // RL1
        if (ticks_diff == '0) begin
            ticks = {1'b1, {SLEEP_W{1'b0}}}; // RL1
        end else begin
            ticks = {1'b0, ticks_diff}; // RL1
        end
        // Round half up: add one half before dropping the fraction bits.
        scaled = 48'(ticks) * 48'(CLOCK_RATIO_FX) + 48'h000000000008; // RL18
        whole  = 44'(scaled >> FRAC_W) + 44'(timer_value_i)
               + 44'(RESTART_OVERHEAD_CYCLES); // RL2 RL3
    end

    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        stored_d   = stored_q;
        ld_timer_d = ld_timer_q;
        ld_ovf_d   = ld_ovf_q;
        reload_d   = 1'b0;
        calc_d     = calc_q;
        rem_d      = rem_q;
        quo_d      = quo_q;
        rem_shift  = {rem_q[TIMER_W-1:0], calc_q[43]};
        unique case (state_q)
            MTSRC_IDLE: begin
                if (run_req_q && !sync_q) begin
                    state_d = MTSRC_RUN; // RL12
                end else if (run_req_q && sleep_edge_i) begin
                    calc_d  = whole;
                    rem_d   = '0;
                    quo_d   = '0;
                    cnt_d   = '0;
                    state_d = MTSRC_CALC; // RL12
                end
            end
            MTSRC_CALC: begin
                // Restoring division, one quotient bit per cycle, so the result is exact
                // for any allowed stop time and ends well inside the start window.
                if (cnt_q < 7'($bits(calc_q))) begin
                    calc_d = {calc_q[42:0], 1'b0};
                    rem_d  = rem_shift;
                    quo_d  = {quo_q[OVF_W-2:0], 1'b0};
                    if (timer_period_i != '0 && rem_shift >= {1'b0, timer_period_i}) begin
                        rem_d = rem_shift - {1'b0, timer_period_i}; // RL3
                        quo_d = {quo_q[OVF_W-2:0], 1'b1}; // RL3
                    end
                end
                cnt_d = cnt_q + 7'h01;
                if (cnt_q == SYNC_START_LAST) begin
                    ld_timer_d = rem_q[TIMER_W-1:0]; // RL3
                    ld_ovf_d   = ld_ovf_q + quo_q; // RL3
                    reload_d   = 1'b1;
                    state_d    = MTSRC_RUN; // RL17 RL15
                end
            end
            MTSRC_RUN: begin
                if (!run_req_q && !sync_q) begin
                    state_d = MTSRC_IDLE; // RL12
                end else if (!run_req_q && sleep_edge_i) begin
                    stored_d = sleep_value_i; // RL16
                    state_d  = MTSRC_IDLE; // RL16 RL15
                end
            end
        endcase
        if (state_q == MTSRC_IDLE && state_d == MTSRC_CALC) begin
            ld_ovf_d = ovf_count_i; // RL3
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q    <= MTSRC_IDLE;
            cnt_q      <= '0;
            stored_q   <= '0;
            ld_timer_q <= '0;
            ld_ovf_q   <= '0;
            reload_q   <= 1'b0;
            calc_q     <= '0;
            rem_q      <= '0;
            quo_q      <= '0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            stored_q   <= stored_d;
            ld_timer_q <= ld_timer_d;
            ld_ovf_q   <= ld_ovf_d;
            reload_q   <= reload_d;
            calc_q     <= calc_d;
            rem_q      <= rem_d;
            quo_q      <= quo_d;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    always_comb begin
        rdata_d               = 8'h00;
        rdata_d[CMP_FLAG_BIT] = cmp_flag_q;
        rdata_d[PER_FLAG_BIT] = per_flag_q;
        rdata_d[OFC_FLAG_BIT] = ofc_flag_q;
        rdata_d[UNUSED_BIT]   = 1'b0; // RL9
        rdata_d[COMPARE_BYTE_SELECT_BIT]    = compare_byte_select_q;
        rdata_d[RSVD_BIT]     = rsvd_q; // RL11
        rdata_d[SYNC_BIT]     = sync_q;
        rdata_d[RUN_BIT]      = (state_d == MTSRC_RUN); // RL14
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_rdata_o           <= 8'h02;
            timer_run_o           <= 1'b0;
            compare_byte_select_o <= 1'b0;
        end else begin
            cfg_rdata_o           <= rdata_d;
            timer_run_o           <= (state_d == MTSRC_RUN); // RL14
            compare_byte_select_o <= compare_byte_select_d; // RL10
        end
    end

    assign reload_o       = reload_q;
    assign reload_timer_o = ld_timer_q;
    assign reload_ovf_o   = ld_ovf_q;

    // =====================================================================
    // Checks
    // =====================================================================
    start_delay_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_q == MTSRC_IDLE && state_d == MTSRC_CALC) |=> ##75 (timer_run_o && reload_o)) // RL17
        else $error("sync start did not run after 75 cycles");
    start_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_q == MTSRC_IDLE && state_d == MTSRC_CALC) |=> !timer_run_o [*8]) // RL15
        else $error("run status changed before sync start");
    cmp_flag_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        compare_event_i |=> cmp_flag_q) // RL5
        else $error("compare flag not set");
    per_flag_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        period_event_i |=> per_flag_q) // RL6
        else $error("period flag not set");
    ofc_flag_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ovf_compare_event_i |=> ofc_flag_q) // RL7
        else $error("overflow compare flag not set");
    flag_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (cmp_flag_q && !(cfg_wr && !sfr_wdata_i[CMP_FLAG_BIT])) |=> cmp_flag_q) // RL8
        else $error("compare flag lost without zero write");
    unused_zero_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !cfg_rdata_o[UNUSED_BIT]) // RL9
        else $error("unused bit read as one");
    async_start_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_q == MTSRC_IDLE && run_req_q && !sync_q) |-> ##1 timer_run_o) // RL12
        else $error("immediate start failed");
    stop_store_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_q == MTSRC_RUN && !run_req_q && sync_q && sleep_edge_i)
        |=> (stored_q == $past(sleep_value_i)) && !timer_run_o) // RL16
        else $error("sync stop did not store sleep value");
    run_read_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        cfg_rdata_o[RUN_BIT] == timer_run_o) // RL14
        else $error("run bit differs from timer state");
    reload_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        reload_o |=> !reload_o) // RL17
        else $error("reload strobe longer than one cycle");
    reload_mod_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (reload_o && timer_period_i != '0) |-> (reload_timer_o < timer_period_i)) // RL3
        else $error("reloaded timer value not below period");
    stop_wait_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_q == MTSRC_RUN && sync_q && !sleep_edge_i) |=> timer_run_o) // RL15
        else $error("sync stop took effect without sleep edge");

endmodule
`default_nettype wire

/* File: verification/mtsrc_top_tb.sv */
// Self-checking testbench for the MAC timer sync-reload and configuration block.
// Assumes the bench stands in for the sleep timer and the counter datapath.
`timescale 1ns/1ps
`default_nettype none
module mtsrc_top_tb
    import mtsrc_pkg::*;
;
    logic                 core_clk;
    logic                 rstn;
    logic                 sfr_wr;
    logic [7:0]           sfr_addr;
    logic [7:0]           sfr_wdata;
    logic [7:0]           cfg;
    logic                 sleep_edge;
    logic [SLEEP_W-1:0]   sleep_value;
    logic [TIMER_W-1:0]   timer_value;
    logic [TIMER_W-1:0]   timer_period;
    logic [OVF_W-1:0]     ovf_count;
    logic [2:0]           ev;
    logic                 timer_run;
    logic                 cms;
    logic                 reload;
    logic [TIMER_W-1:0]   reload_timer;
    logic [OVF_W-1:0]     reload_ovf;
    int                   err_count;
    int                   samples_checked;
    int                   cycles;

    mtsrc_top i_dut (
        .core_clk_i            (core_clk),
        .rstn_i                (rstn),
        .sfr_wr_i              (sfr_wr),
        .sfr_addr_i            (sfr_addr),
        .sfr_wdata_i           (sfr_wdata),
        .cfg_rdata_o           (cfg),
        .sleep_edge_i          (sleep_edge),
        .sleep_value_i         (sleep_value),
        .timer_value_i         (timer_value),
        .timer_period_i        (timer_period),
        .ovf_count_i           (ovf_count),
        .compare_event_i       (ev[2]),
        .period_event_i        (ev[1]),
        .ovf_compare_event_i   (ev[0]),
        .timer_run_o           (timer_run),
        .compare_byte_select_o (cms),
        .reload_o              (reload),
        .reload_timer_o        (reload_timer),
        .reload_ovf_o          (reload_ovf)
    );

    // =====================================================================
    // Shared tasks
    // =====================================================================
    task automatic results();
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The write is taken one edge after launch and read back one edge later.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        sfr_wr    <= 1'b1;
        sfr_addr  <= addr;
        sfr_wdata <= data;
        @(posedge core_clk);
        sfr_wr    <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic sleep_pulse(input logic [23:0] val);
        @(posedge core_clk);
        sleep_value <= val;
        sleep_edge  <= 1'b1;
        @(posedge core_clk);
        sleep_edge  <= 1'b0;
    endtask

    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic t_flags();
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            ev <= 3'(3'b100 >> i);
            @(posedge core_clk);
            ev <= 3'b000;
            repeat (2) @(posedge core_clk);
            #1;
            chk(24'({3'(3'b100 >> i), 5'h02}), 24'(cfg));
            wr(CFG_ADDR, 8'hF2);
            chk(24'({3'(3'b100 >> i), 5'h02}), 24'(cfg));
            wr(CFG_ADDR, 8'h02);
            chk(24'(cfg), 24'h02);
        end
        wr(8'hC4, 8'h0A);
        chk(24'(cfg), 24'h02);
    endtask

    task automatic t_compare_byte_select();
        wr(CFG_ADDR, 8'h0A);
        chk(24'({cfg, cms}), 24'h015);
        wr(CFG_ADDR, 8'h02);
        chk(24'(cms), 24'h0);
    endtask

    task automatic sync_start(input logic [23:0] nc, input logic [15:0] t,
                              input logic [19:0] o, input bit vals);
        int n;
        n = 0;
        wr(CFG_ADDR, 8'h03);
        chk(24'(cfg[RUN_BIT]), 24'h0);
        sleep_pulse(nc);
        while (reload !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
            if (n == 1) chk(24'(timer_run), 24'h0);
        end
        chk(24'(n), 24'd75);
        chk(24'(timer_run), 24'h1);
        if (vals) chk(24'(reload_timer), 24'(t));
        if (vals) chk(24'(reload_ovf), 24'(o));
        @(posedge core_clk);
        #1;
        chk(24'({reload, cfg[RUN_BIT]}), 24'h1);
    endtask

    task automatic sync_stop(input logic [23:0] ns);
        wr(CFG_ADDR, 8'h02);
        repeat (3) @(posedge core_clk);
        #1;
        chk(24'({timer_run, cfg[RUN_BIT]}), 24'h3);
        sleep_pulse(ns);
        repeat (2) @(posedge core_clk);
        #1;
        chk(24'({timer_run, cfg[RUN_BIT]}), 24'h0);
    endtask

    // A reset in mid-run restores the reset view and a clean stored sleep value.
    task automatic t_reset();
        wr(CFG_ADDR, 8'h09);
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1;
        chk(24'({cfg, timer_run, cms}), 24'h000008);
        sync_start(24'h000010, 16'h0320, 20'h00014, 1'b1);
    endtask

    task automatic t_immediate();
        wr(CFG_ADDR, 8'h01);
        @(posedge core_clk);
        #1;
        chk(24'(timer_run), 24'h1);
        @(posedge core_clk);
        #1;
        chk(24'(cfg[RUN_BIT]), 24'h1);
        wr(CFG_ADDR, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        chk(24'({timer_run, cfg[RUN_BIT]}), 24'h0);
    endtask

    // =====================================================================
    // Clock, timeout and main sequence
    // =====================================================================
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            results();
        end
    end

    initial begin
        rstn = 1'b0;
        sfr_wr = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sleep_edge = 1'b0;
        sleep_value = 24'h000000;
        timer_value = 16'h0064;
        timer_period = 16'h03E8;
        ovf_count = 20'h00005;
        ev = 3'b000;
        err_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1;
        chk(24'({cfg, timer_run}), 24'h004);
        t_flags();
        t_compare_byte_select();
        sync_start(24'h000010, 16'h0320, 20'h00014, 1'b1);
        // Crossing the sleep timer wrap leaves two elapsed ticks.
        sync_stop(24'hFFFFFF);
        sync_start(24'h000001, 16'h0080, 20'h00007, 1'b1);
        // Eight ticks give a half-cycle fraction that rounds up.
        sync_stop(24'h000010);
        sync_start(24'h000018, 16'h03DC, 20'h0000C, 1'b1);
        sync_stop(24'h000020);
        t_immediate();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
